// ===== hdl/lmdc_top.sv
// Purpose: colour invert, power save and memory clock enable control
// Assumes: mclk is the pixel clock; request pins asynchronous
// Notes: memory clock is a one-cycle enable pulse, not a real clock
`timescale 1ns/1ps
module lmdc_top #(
   parameter int LUT_W = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins
   input wire logic invert_request_pin,
   input wire logic power_save_request_pin,
   // colour path
   input wire logic [LUT_W-1:0] lut_data,
   output logic [LUT_W-1:0] pix_data,
   // control outputs
   output logic mem_clk_en,
   output logic power_save,
   output logic rot_active,
   output logic rot_alt
);
   lmdc_pkg::lmdc_ctrl_t ctrl, next_ctrl;
   logic ack, next_ack;
   logic [31:0] rdat, next_rdat;
   logic [1:0] inv_sync, ps_sync, next_inv_sync, next_ps_sync;
   logic next_mem_clk_en, next_power_save, next_rot_active, next_rot_alt;
   logic wr_take;
   logic [2:0] div_cnt, next_div_cnt, div_load;
   logic inv_act, ps_act;
   logic [LUT_W-1:0] next_pix;
   logic req;

   assign req = wb_cyc_i && wb_stb_i && !ack;
   // a write lands at the edge where the master sees ack, as a classic cycle expects
   assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && ack;

   // register bus: one wait state, unmapped reads give zero
   always_comb begin
      next_ctrl = ctrl;
      next_ack = req;
      next_rdat = 32'h0000_0000;
      if (wr_take && wb_adr_i == lmdc_pkg::LMDC_CTRL_OFS) begin
         if (wb_sel_i[0]) begin
            next_ctrl[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            next_ctrl[9:8] = wb_dat_i[9:8];
         end
      end
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            lmdc_pkg::LMDC_CTRL_OFS: next_rdat = {22'h00_0000, ctrl};
            lmdc_pkg::LMDC_STAT_OFS: next_rdat = {28'h000_0000, rot_alt, rot_active,
                                                  ps_act, inv_act};
            default: next_rdat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl <= lmdc_pkg::LMDC_CTRL_RST;
         ack <= 1'b0;
         rdat <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         ack <= next_ack;
         rdat <= next_rdat;
      end
   end
   assign wb_ack_o = ack;
   assign wb_dat_o = rdat;

   // pin synchronisers; first stage read only by second
   always_comb begin
      next_inv_sync = {inv_sync[0], invert_request_pin};
      next_ps_sync = {ps_sync[0], power_save_request_pin};
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         inv_sync <= 2'h0;
         ps_sync <= 2'h0;
      end else begin
         inv_sync <= next_inv_sync;
         ps_sync <= next_ps_sync;
      end
   end

   // pin path toggles the software sense; panel data use blocks it
   assign inv_act = ctrl.sw_inv ^ (inv_sync[1] && ctrl.hw_inv_en && !ctrl.tft);
   assign ps_act = ctrl.sw_ps || (ps_sync[1] && ctrl.hw_ps_en);
   // invert after the table so the result is a true colour inverse
   assign next_pix = inv_act ? ~lut_data : lut_data;

   // divider reload chosen by depth, overridden by high performance
   always_comb begin
      case (ctrl.bpp)
         lmdc_pkg::LMDC_BPP1: div_load = lmdc_pkg::LMDC_DIV8;
         lmdc_pkg::LMDC_BPP2: div_load = lmdc_pkg::LMDC_DIV4;
         lmdc_pkg::LMDC_BPP4: div_load = lmdc_pkg::LMDC_DIV2;
         default: div_load = lmdc_pkg::LMDC_DIV1;
      endcase
      if (ctrl.hiperf) begin
         div_load = lmdc_pkg::LMDC_DIV1;
      end
      next_div_cnt = (div_cnt == 3'h0 || div_cnt > div_load) ? div_load : div_cnt - 3'h1;
   end

   // output next values; all registered so the pins never see comb glitches
   always_comb begin
      next_mem_clk_en = (next_div_cnt == 3'h0);
      next_power_save = ps_act;
      next_rot_active = ctrl.rot_en;
      next_rot_alt = ctrl.rot_en && ctrl.rot_alt;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         div_cnt <= 3'h0;
         mem_clk_en <= 1'b0;
         pix_data <= '0;
         power_save <= 1'b0;
         rot_active <= 1'b0;
         rot_alt <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         mem_clk_en <= next_mem_clk_en;
         pix_data <= next_pix;
         power_save <= next_power_save;
         rot_active <= next_rot_active;
         rot_alt <= next_rot_alt;
      end
   end

   // helper: cycles since the last enable pulse; saturates so a long gap never wraps
   logic [3:0] gap, next_gap;
   always_comb begin
      next_gap = gap;
      if (mem_clk_en) begin
         next_gap = 4'h0;
      end else if (gap != 4'hf) begin
         next_gap = gap + 4'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         gap <= 4'h0;
      end else begin
         gap <= next_gap;
      end
   end

   // register bus: answer one cycle after the take, one-cycle pulse, data only with it
   a_ack_answer: assert property (@(posedge mclk) disable iff (srst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered after one cycle");
   a_ack_pulse: assert property (@(posedge mclk) disable iff (srst)
      wb_ack_o |=> !wb_ack_o)
      else $error("bus acknowledge longer than one cycle");
   a_rdat_idle: assert property (@(posedge mclk) disable iff (srst)
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data shown outside an answer");

   // memory clock divider; ctrl must hold still so a rate change is not blamed
   a_hiperf_every: assert property (@(posedge mclk) disable iff (srst)
      ctrl.hiperf && $past(ctrl.hiperf) && $past(ctrl.hiperf, 2) |-> mem_clk_en)
      else $error("memory clock enable missing in high performance");
   a_div8_gap: assert property (@(posedge mclk) disable iff (srst)
      mem_clk_en && !ctrl.hiperf && ctrl.bpp == lmdc_pkg::LMDC_BPP1 ##1
      (!ctrl.hiperf && ctrl.bpp == lmdc_pkg::LMDC_BPP1)[*7] |=> mem_clk_en)
      else $error("divide by eight period wrong");
   a_div4_gap: assert property (@(posedge mclk) disable iff (srst)
      mem_clk_en && !ctrl.hiperf && ctrl.bpp == lmdc_pkg::LMDC_BPP2 ##1
      (!ctrl.hiperf && ctrl.bpp == lmdc_pkg::LMDC_BPP2)[*3] |=> mem_clk_en)
      else $error("divide by four period wrong");
   a_div2_gap: assert property (@(posedge mclk) disable iff (srst)
      mem_clk_en && !ctrl.hiperf && ctrl.bpp == lmdc_pkg::LMDC_BPP4 ##1
      (!ctrl.hiperf && ctrl.bpp == lmdc_pkg::LMDC_BPP4) |=> mem_clk_en)
      else $error("divide by two period wrong");
   a_div_nofast: assert property (@(posedge mclk) disable iff (srst)
      mem_clk_en && !ctrl.hiperf && ctrl.bpp == lmdc_pkg::LMDC_BPP2 && ctrl == $past(ctrl)
      && ctrl == $past(ctrl, 2) && ctrl == $past(ctrl, 3) |-> gap >= 4'h3)
      else $error("divide by four pulse too early");

   // colour path and pin gating
   a_inv_lut: assert property (@(posedge mclk) disable iff (srst)
      1'h1 |=> pix_data == ($past(inv_act) ? ~$past(lut_data) : $past(lut_data)))
      else $error("pixel output not table value or its inverse");
   a_inv_pin: assert property (@(posedge mclk) disable iff (srst)
      !ctrl.hw_inv_en |-> inv_act == ctrl.sw_inv)
      else $error("pin inversion acted while disabled");
   a_inv_tft: assert property (@(posedge mclk) disable iff (srst)
      ctrl.tft |-> inv_act == ctrl.sw_inv)
      else $error("pin inversion acted with active matrix panel");

   // power save from software or from the pin
   a_ps_sw: assert property (@(posedge mclk) disable iff (srst)
      ctrl.sw_ps |=> power_save)
      else $error("software power save not taken");
   a_ps_pin: assert property (@(posedge mclk) disable iff (srst)
      $rose(ps_sync[1]) && ctrl.hw_ps_en && $past(ctrl.hw_ps_en) |=> power_save)
      else $error("pin power save not taken");
   a_ps_block: assert property (@(posedge mclk) disable iff (srst)
      !ctrl.sw_ps && !ctrl.hw_ps_en |=> !power_save || $past(srst))
      else $error("power save without a request");

   // synchroniser latency and rotation outputs
   a_sync_lat: assert property (@(posedge mclk) disable iff (srst)
      $rose(invert_request_pin) ##1 invert_request_pin |=> inv_sync[1])
      else $error("invert pin synchroniser latency wrong");
   a_ps_sync_lat: assert property (@(posedge mclk) disable iff (srst)
      $rose(power_save_request_pin) ##1 power_save_request_pin |=> ps_sync[1])
      else $error("power save pin synchroniser latency wrong");
   a_rot_follow: assert property (@(posedge mclk) disable iff (srst)
      1'h1 |=> rot_active == $past(ctrl.rot_en))
      else $error("rotation output does not follow control");
   a_rot_alt: assert property (@(posedge mclk) disable iff (srst)
      rot_alt |-> rot_active)
      else $error("alternate rotation without rotation");

   // main scenarios to be seen in a run
   c_hiperf: cover property (@(posedge mclk) ctrl.hiperf ##1 mem_clk_en[*3]);
   c_pin_inv: cover property (@(posedge mclk) ctrl.hw_inv_en && inv_sync[1] && inv_act);
   c_pin_ps: cover property (@(posedge mclk) ctrl.hw_ps_en && !ctrl.sw_ps ##1 power_save);
   c_div8: cover property (@(posedge mclk) ctrl.bpp == lmdc_pkg::LMDC_BPP1 && mem_clk_en);
   c_rot_alt: cover property (@(posedge mclk) rot_alt);
endmodule

// ===== hdl/lmdc_pkg.sv
// Purpose: constants and types for the misc display control block
// Assumes: 32-bit classic wishbone, byte addresses, one clock
// Notes: the control and status registers sit at offsets below
// Functional notes
// - invert toggles by software bit or by pin level when hardware invert enabled
// - inversion applies to colour value leaving the look-up table, not memory data
// - with active-matrix panel selected pin inversion is off, software still works
// - power save by software bit or by pin when hardware power save enabled
// - normal mode: memory clock divides pixel clock by 8,4,2,1 for 1,2,4,8 bpp
// - high performance: memory clock equals pixel clock at all depths
// - two rotation schemes: default lower power, alternate faster higher power
package lmdc_pkg;
   localparam logic [7:0] LMDC_CTRL_OFS = 8'h00;
   localparam logic [7:0] LMDC_STAT_OFS = 8'h04;
   // control field positions
   localparam int LMDC_SW_INV_BIT = 0;
   localparam int LMDC_HW_INV_EN_BIT = 1;
   localparam int LMDC_SW_PS_BIT = 2;
   localparam int LMDC_HW_PS_EN_BIT = 3;
   localparam int LMDC_HIPERF_BIT = 4;
   localparam int LMDC_TFT_BIT = 5;
   localparam int LMDC_ROT_EN_BIT = 6;
   localparam int LMDC_ROT_ALT_BIT = 7;
   localparam int LMDC_BPP_LSB = 8;
   localparam int LMDC_CTRL_W = 10;
   localparam logic [9:0] LMDC_CTRL_RST = 10'h000;
   // colour depth codes
   localparam logic [1:0] LMDC_BPP1 = 2'h0;
   localparam logic [1:0] LMDC_BPP2 = 2'h1;
   localparam logic [1:0] LMDC_BPP4 = 2'h2;
   localparam logic [1:0] LMDC_BPP8 = 2'h3;
   // divider reload values (divide minus one)
   localparam logic [2:0] LMDC_DIV8 = 3'h7;
   localparam logic [2:0] LMDC_DIV4 = 3'h3;
   localparam logic [2:0] LMDC_DIV2 = 3'h1;
   localparam logic [2:0] LMDC_DIV1 = 3'h0;
   typedef struct packed {
      logic [1:0] bpp;
      logic rot_alt;
      logic rot_en;
      logic tft;
      logic hiperf;
      logic hw_ps_en;
      logic sw_ps;
      logic hw_inv_en;
      logic sw_inv;
   } lmdc_ctrl_t;
endpackage

// ===== test/lmdc_pins.sv
// Purpose: far-side model of the two request pins
// Assumes: levels are requested by the bench and launched after a clock edge
// Notes: the pins carry no clock of their own, so the block must resync them
`timescale 1ns/1ps
module lmdc_pins (
   // clock
   input wire logic mclk,
   // requested levels
   input wire logic inv_lvl,
   input wire logic ps_lvl,
   // pins
   output logic invert_request_pin = 1'b0,
   output logic power_save_request_pin = 1'b0
);
   // plain levels, held until the next request
   always @(posedge mclk) begin
      invert_request_pin <= inv_lvl;
      power_save_request_pin <= ps_lvl;
   end
endmodule

// ===== test/lcd_misc_display_control_test.sv
// Purpose: self-checking bench for the misc display control block
// Assumes: ack comes one cycle after a taken request
// Notes: pin effects are waited out over the sync stages
`timescale 1ns/1ps
module lcd_misc_display_control_test;
   logic mclk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h3;
   logic [31:0] wd = 32'h0000_0000, rd, dat_o;
   logic ack, inv_lvl = 0, ps_lvl = 0, inv_pin, ps_pin, mce, ps, ra, rl;
   logic [7:0] lut = 8'ha5, pix;
   int err_count = 0, n_tests = 0;
   // 125 MHz clock
   always #4 mclk = ~mclk;
   lmdc_pins PINS (.mclk(mclk), .inv_lvl(inv_lvl), .ps_lvl(ps_lvl),
      .invert_request_pin(inv_pin), .power_save_request_pin(ps_pin));
   lmdc_top DUT (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .invert_request_pin(inv_pin), .power_save_request_pin(ps_pin), .lut_data(lut),
      .pix_data(pix), .mem_clk_en(mce), .power_save(ps), .rot_active(ra), .rot_alt(rl));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one classic cycle; the request stands until ack is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         $display("[ERR] bus ack expected 1 seen %b", ack);
      end
      rd = dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic set_ctrl(input logic [31:0] v);
      xfer(1, lmdc_pkg::LMDC_CTRL_OFS, v);
      repeat (3) @(posedge mclk);
   endtask
   // two sync flops and an output flop, with margin
   task automatic settle;
      repeat (6) @(posedge mclk);
   endtask
   task automatic t_reset;
      xfer(0, lmdc_pkg::LMDC_CTRL_OFS, 32'h0000_0000);
      chk("ctrl reset", 32'h0000_0000, rd);
      xfer(0, 8'h10, 32'h0000_0000);
      chk("unmapped read", 32'h0000_0000, rd);
      chk("pix plain", 32'h0000_00a5, {24'h00_0000, pix});
   endtask
   task automatic t_invert;
      set_ctrl(32'h0000_0001);
      chk("pix sw invert", 32'h0000_005a, {24'h00_0000, pix});
      xfer(0, lmdc_pkg::LMDC_STAT_OFS, 32'h0000_0000);
      chk("stat invert", 32'h0000_0001, rd & 32'h0000_0001);
      set_ctrl(32'h0000_0002);
      inv_lvl <= 1;
      @(posedge mclk);
      @(posedge mclk);
      chk("pix before sync", 32'h0000_00a5, {24'h00_0000, pix});
      settle;
      chk("pix pin invert", 32'h0000_005a, {24'h00_0000, pix});
      set_ctrl(32'h0000_0003);
      chk("pix pin toggles sw", 32'h0000_00a5, {24'h00_0000, pix});
      set_ctrl(32'h0000_0023);
      chk("pix tft sw only", 32'h0000_005a, {24'h00_0000, pix});
      set_ctrl(32'h0000_0000);
      chk("pix pin no enable", 32'h0000_00a5, {24'h00_0000, pix});
      inv_lvl <= 0;
   endtask
   task automatic t_psave;
      set_ctrl(32'h0000_0004);
      chk("ps sw", 32'h0000_0001, {31'h0, ps});
      set_ctrl(32'h0000_0000);
      ps_lvl <= 1;
      settle;
      chk("ps pin no enable", 32'h0000_0000, {31'h0, ps});
      set_ctrl(32'h0000_0008);
      settle;
      chk("ps pin", 32'h0000_0001, {31'h0, ps});
      xfer(0, lmdc_pkg::LMDC_STAT_OFS, 32'h0000_0000);
      chk("stat power save", 32'h0000_0002, rd);
      ps_lvl <= 0;
      settle;
      chk("ps pin off", 32'h0000_0000, {31'h0, ps});
   endtask
   // depth codes are written as software would for a small panel
   task automatic t_mclk;
      int cnt;
      for (int h = 0; h < 2; h++) begin
         for (int b = 0; b < 4; b++) begin
            set_ctrl((h << 4) | (b << 8));
            cnt = 0;
            repeat (16) begin
               @(posedge mclk);
               if (mce === 1'b1) cnt++;
            end
            chk("mem clk pulses", (h == 1) ? 16 : (16 >> (3 - b)), cnt);
         end
      end
   endtask
   task automatic t_rot;
      set_ctrl(32'h0000_0040);
      chk("rot default", 32'h0000_0002, {30'h0, ra, rl});
      set_ctrl(32'h0000_00c0);
      chk("rot alternate", 32'h0000_0003, {30'h0, ra, rl});
      xfer(0, lmdc_pkg::LMDC_STAT_OFS, 32'h0000_0000);
      chk("stat rotation", 32'h0000_000c, rd);
      set_ctrl(32'h0000_0080);
      chk("rot alt needs enable", 32'h0000_0000, {30'h0, ra, rl});
      // upper lane must keep the depth when only lane 0 is written
      set_ctrl(32'h0000_0300);
      sel <= 4'h1;
      set_ctrl(32'h0000_0040);
      sel <= 4'h3;
      xfer(0, lmdc_pkg::LMDC_CTRL_OFS, 32'h0000_0000);
      chk("ctrl low lane only", 32'h0000_0340, rd);
   endtask
   // reset in mid run must clear control, power save, rotation and pixel inversion
   task automatic t_midrst;
      set_ctrl(32'h0000_0055);
      srst <= 1;
      repeat (2) @(posedge mclk);
      srst <= 0;
      xfer(0, lmdc_pkg::LMDC_CTRL_OFS, 32'h0000_0000);
      chk("ctrl after reset", 32'h0000_0000, rd);
      chk("ps after reset", 32'h0000_0000, {31'h0, ps});
      chk("rot after reset", 32'h0000_0000, {30'h0, ra, rl});
      chk("pix after reset", 32'h0000_00a5, {24'h00_0000, pix});
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // main sequence after two cycles of reset
   initial begin
      repeat (2) @(posedge mclk);
      srst <= 0;
      t_reset;
      t_invert;
      t_psave;
      t_mclk;
      t_rot;
      t_midrst;
      final_report;
   end
   // the tests take well under this span
   initial begin
      #200000;
      err_count++;
      final_report;
   end
endmodule
